// File: verification/dit_top_tb_top.sv
`timescale 1ns/10ps
// ============================================================
// compare helper: counts every check, reports a mismatch
// ============================================================
`define CHK(nm, ex, got) begin \
	checks++; \
	if ((got) !== (ex)) begin \
		fails++; \
		$display("ERROR %s expected %h seen %h", nm, ex, got); \
	end \
end

module dit_top_tb_top
	import dit_pkg::*;
;
	// ========================================================
	// stimulus and observed signals
	// ========================================================
	logic        pclk;         // 100 MHz bus and gear clock
	logic        presetn;      // active-low reset
	logic        psel;         // apb select
	logic        penable;      // apb access phase
	logic        pwrite;       // apb direction
	logic [7:0]  paddr;        // apb byte address
	logic [31:0] pwdata;       // apb write data
	logic [31:0] prdata;       // apb read data
	logic        pready;       // apb ready
	logic        pslverr;      // apb error
	logic        low_freq_clk; // slow oscillator, pclk/8
	logic        lf_osc_ok;    // oscillator running
	logic        slow_mode;    // slow or sleep power mode
	logic        stop_mode;    // chip stop mode
	logic        irq;          // level interrupt
	logic        match_irq_lo; // lo match pulse
	logic        match_irq_hi; // hi match pulse
	logic [2:0]  lfc;          // divider for the slow clock
	logic [31:0] d;            // last read data
	logic        e;            // last read error
	int          n;            // measured period in cycles
	int          k;            // cycles to the first pulse
	int          checks;       // comparisons made
	int          fails;        // mismatches seen
	int          cyc;          // cycles since start

	dit_top dit_top_i (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.low_freq_clk(low_freq_clk),
		.lf_osc_ok   (lf_osc_ok),
		.slow_mode   (slow_mode),
		.stop_mode   (stop_mode),
		.irq         (irq),
		.match_irq_lo(match_irq_lo),
		.match_irq_hi(match_irq_hi)
	);

	// ========================================================
	// clocks and timeout
	// ========================================================
	// free-running slow clock, an exact multiple of pclk so
	// every prescaled period is a fixed number of cycles
	assign low_freq_clk = lfc[2];

	// clock generator
	always #5 pclk = ~pclk;

	// slow clock divider and hang guard
	always @(posedge pclk) begin
		lfc <= lfc + 3'h1;
		cyc++;
		if (cyc == 30000) begin
			fails++;
			report_and_stop();
		end
	end

	// ========================================================
	// apb master tasks: entered just after a rising edge
	// ========================================================
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// idle cycle keeps the next setup off this edge
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// run lo in a non-interval mode, then read its counter;
	// compare 0 means a wrongly counting timer climbs freely
	task automatic no_count(input logic [7:0] m);
		wr(OFS_PAIR, 32'h0);
		wr(OFS_MODE_LO, {24'h0, m});
		wr(OFS_CMP_LO, 32'h0);
		wr(OFS_PAIR, 32'h1);
		repeat (20) @(posedge pclk);
		rd(OFS_CNT_LO);
	endtask : no_count

	// cycles between two match pulses of one timer
	task automatic per(input logic hi);
		k = 0;
		n = 0;
		@(posedge pclk);
		while ((hi ? match_irq_hi : match_irq_lo) !== 1'b1 && k < 3000)
		begin
			@(posedge pclk);
			k++;
		end
		do begin
			@(posedge pclk);
			n++;
		end while ((hi ? match_irq_hi : match_irq_lo) !== 1'b1 &&
			n < 3000);
	endtask : per

	task automatic tdone(input string nm);
		$display("test %s finished", nm);
	endtask : tdone

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// ========================================================
	// main sequence
	// ========================================================
	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; lfc = 3'h0;
		lf_osc_ok = 1'b1; slow_mode = 1'b0; stop_mode = 1'b0;
		checks = 0; fails = 0; cyc = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		// reset state, unmapped place, writes refused while gated
		rd(OFS_GATE);
		`CHK("gate reset", 32'h0, d)
		rd(8'h30);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, d)
		wr(OFS_MODE_LO, 32'h70);
		rd(OFS_MODE_LO);
		`CHK("mode while gated", 32'h0, d)
		wr(OFS_PAIR, 32'h1);
		rd(OFS_PAIR);
		`CHK("run while gated", 32'h0, d)
		tdone("reset");
		// gate on first, then mode, compare, enable, run
		// the gate then stays open for the whole run
		wr(OFS_GATE, 32'h10);
		rd(OFS_GATE);
		`CHK("gate on", 32'h10, d)
		wr(OFS_MODE_LO, 32'h70);
		wr(OFS_CMP_LO, 32'h3);
		wr(OFS_IEN, 32'h1);
		wr(OFS_PAIR, 32'h1);
		per(1'b0);
		`CHK("lo period", 3, n)
		rd(OFS_STS);
		`CHK("lo status", 32'h1, d)
		`CHK("irq on", 1'b1, irq)
		wr(OFS_MODE_LO, 32'h00);
		rd(OFS_MODE_LO);
		`CHK("mode locked", 32'h70, d)
		wr(OFS_IEN, 32'h0);
		`CHK("irq masked", 1'b0, irq)
		wr(OFS_PAIR, 32'h0);
		rd(OFS_CNT_LO);
		`CHK("lo stopped", 32'h0, d)
		wr(OFS_CLR, 32'h3);
		rd(OFS_STS);
		`CHK("status cleared", 32'h0, d)
		tdone("interval lo");
		// hi timer alone, gear divided by two
		wr(OFS_MODE_HI, 32'h60);
		wr(OFS_CMP_HI, 32'h2);
		wr(OFS_IEN, 32'h2);
		wr(OFS_PAIR, 32'h2);
		per(1'b1);
		`CHK("hi period", 4, n)
		rd(OFS_STS);
		`CHK("hi status", 32'h2, d)
		`CHK("hi irq", 1'b1, irq)
		rd(OFS_CNT_LO);
		`CHK("lo idle", 32'h0, d)
		wr(OFS_PAIR, 32'h0);
		wr(OFS_CLR, 32'h3);
		tdone("interval hi");
		// cascade: slow lo select must not matter
		wr(OFS_MODE_LO, 32'h00);
		wr(OFS_MODE_HI, 32'h70);
		wr(OFS_CMP_LO, 32'h2);
		wr(OFS_CMP_HI, 32'h0);
		wr(OFS_PAIR, 32'h6);
		per(1'b0);
		`CHK("cascade period", 2, n)
		stop_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		stop_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		rd(OFS_PAIR);
		`CHK("run after stop", 2'b00, d[1:0])
		wr(OFS_PAIR, 32'h0);
		tdone("cascade");
		// slow power mode: code 111 is the slow clock over four
		wr(OFS_MODE_LO, 32'h70);
		slow_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		wr(OFS_PAIR, 32'h1);
		per(1'b0);
		`CHK("slow period", 64, n)
		wr(OFS_PAIR, 32'h0);
		lf_osc_ok <= 1'b0;
		repeat (3) @(posedge pclk);
		wr(OFS_PAIR, 32'h1);
		repeat (200) @(posedge pclk);
		rd(OFS_CNT_LO);
		`CHK("dead oscillator", 32'h0, d)
		wr(OFS_PAIR, 32'h0);
		lf_osc_ok <= 1'b1;
		slow_mode <= 1'b0;
		tdone("slow clock");
		// normal mode with slow taps: code 001 gives over eight
		wr(OFS_CFG, 32'h1);
		wr(OFS_MODE_LO, 32'h10);
		wr(OFS_CMP_LO, 32'h1);
		wr(OFS_PAIR, 32'h1);
		per(1'b0);
		`CHK("lf tap period", 64, n)
		wr(OFS_PAIR, 32'h0);
		tdone("slow taps");
		// double buffer: a running write waits for the old match
		wr(OFS_MODE_LO, 32'hf0);
		wr(OFS_CMP_LO, 32'h3);
		wr(OFS_PAIR, 32'h1);
		wr(OFS_CMP_LO, 32'hc8);
		per(1'b0);
		`CHK("dbuf early match", 1'b1, k < 8)
		`CHK("dbuf period", 200, n)
		rd(OFS_CMP_LO);
		`CHK("compare readback", 32'hc8, d)
		tdone("double buffer");
		// op 10 and external select must leave the counter still
		no_count(8'h78);
		`CHK("op 10 idle", 32'h0, d)
		no_count(8'h71);
		`CHK("ext select idle", 32'h0, d)
		tdone("other modes");
		report_and_stop();
	end

endmodule : dit_top_tb_top

// File: verilog/dit_chan.sv
`timescale 1ns/10ps
// ============================================================
// one 8-bit up counter with double-buffered compare
// ============================================================
module dit_chan
	import dit_pkg::*;
#(
	parameter int W = 8                  // counter width
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// counter control
	input  wire logic         inc,       // count one source tick
	input  wire logic         clr,       // compare match, restart
	input  wire logic         halt,      // stopped: hold at zero
	// compare write
	input  wire logic         cmp_wr,    // software write strobe
	input  wire logic [W-1:0] cmp_wdata, // written value
	input  wire logic         dbuf_en,   // writes go via buffer
	// state out
	output logic      [W-1:0] cnt_q,     // counter value
	output logic      [W-1:0] act_q,     // compare in use
	output logic      [W-1:0] buf_q      // last value written
);

	// ========================================================
	// next state
	// ========================================================
	logic [W-1:0] cnt_d; // next counter
	logic [W-1:0] act_d; // next active compare
	logic [W-1:0] buf_d; // next buffer

	// counter and compare update
	always_comb begin
		cnt_d = cnt_q;
		act_d = act_q;
		buf_d = buf_q;
		// a stopped counter sits at zero, so restart is clean
		if (halt) begin
			cnt_d = '0;
		end else if (clr) begin
			cnt_d = '0;
		end else if (inc) begin
			cnt_d = cnt_q + W'(1);
		end
		if (cmp_wr) begin
			buf_d = cmp_wdata;
		end
		// buffered write waits for the next match to take over
		if (cmp_wr && (halt || !dbuf_en)) begin
			act_d = cmp_wdata;
		end else if (clr) begin
			act_d = buf_q;
		end
	end

	// ========================================================
	// registers
	// ========================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			act_q <= W'(CMP_RST);
			buf_q <= W'(CMP_RST);
		end else begin
			cnt_q <= cnt_d;
			act_q <= act_d;
			buf_q <= buf_d;
		end
	end

endmodule : dit_chan

// File: verilog/dit_pkg.sv
// ============================================================
// dual 8-bit interval timer: shared constants and types
// ============================================================
package dit_pkg;

	// ========================================================
	// register byte offsets
	// ========================================================
	localparam logic [7:0] OFS_GATE    = 8'h00; // power_gate_reg
	localparam logic [7:0] OFS_PAIR    = 8'h04; // timer_pair_ctl
	localparam logic [7:0] OFS_MODE_LO = 8'h08; // timer_mode_reg, lo
	localparam logic [7:0] OFS_MODE_HI = 8'h0c; // timer_mode_reg, hi
	localparam logic [7:0] OFS_CMP_LO  = 8'h10; // compare_reg, lo
	localparam logic [7:0] OFS_CMP_HI  = 8'h14; // compare_reg, hi
	localparam logic [7:0] OFS_CNT_LO  = 8'h18; // counter lo, read only
	localparam logic [7:0] OFS_CNT_HI  = 8'h1c; // counter hi, read only
	localparam logic [7:0] OFS_STS     = 8'h20; // irq status, read only
	localparam logic [7:0] OFS_CLR     = 8'h24; // irq clear, write only
	localparam logic [7:0] OFS_IEN     = 8'h28; // irq enable
	localparam logic [7:0] OFS_CFG     = 8'h2c; // clock config

	// ========================================================
	// field positions
	// ========================================================
	localparam int GATE_EN_BIT = 4;          // pair_clk_gate_en
	localparam int RUN_LO_BIT  = 0;          // run_bit_lo
	localparam int RUN_HI_BIT  = 1;          // run_bit_hi
	localparam int CASC_BIT    = 2;          // cascade control
	localparam int LFSEL_BIT   = 0;          // low-frequency divider pick
	localparam int STS_LO_BIT  = 0;          // lo (or 16-bit) match
	localparam int STS_HI_BIT  = 1;          // hi match

	// ========================================================
	// reset values
	// ========================================================
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CMP_RST  = 8'h00;
	localparam logic [1:0] IEN_RST  = 2'h0;

	// ========================================================
	// clock select codes and divider widths
	// ========================================================
	localparam logic [2:0] SRC_DIV16 = 3'h0; // lf/16 when lf chosen
	localparam logic [2:0] SRC_DIV8  = 3'h1; // lf/8 when lf chosen
	localparam logic [2:0] SRC_DIV1  = 3'h7; // lf/4 in slow modes
	localparam int         GPRE_W    = 11;   // gear prescaler width
	localparam int         LPRE_W    = 4;    // low-freq prescaler width

	// mode register layout: {dbuf, src[2:0], op[1:0], spare, ext}
	typedef struct packed {
		logic       dbuf_enable;
		logic [2:0] src_clk_sel;
		logic [1:0] op_mode_sel;
		logic       spare;
		logic       ext_clk_sel;
	} dit_mode_t;

	// clock environment seen by the source selector
	typedef struct packed {
		logic slow;   // slow or sleep power mode
		logic lfsel;  // low-frequency taps on codes 000/001
		logic lfok;   // low-frequency oscillator running
	} dit_env_t;

	// gear prescaler mask per select code, 2^11 down to 1
	function automatic logic [GPRE_W-1:0] gear_mask(
		input logic [2:0] code);
		unique case (code)
			3'h0: gear_mask = 11'h7ff;
			3'h1: gear_mask = 11'h3ff;
			3'h2: gear_mask = 11'h0ff;
			3'h3: gear_mask = 11'h03f;
			3'h4: gear_mask = 11'h00f;
			3'h5: gear_mask = 11'h003;
			3'h6: gear_mask = 11'h001;
			3'h7: gear_mask = 11'h000;
		endcase
	endfunction : gear_mask

endpackage : dit_pkg

// File: verilog/dit_top.sv
`timescale 1ns/10ps
// Behaviour
// R1: interval mode needs op 0x, no cascade, internal
// R2: normal modes: code picks gear or lf divider
// R3: slow modes allow only codes 000,001,111
// R4: cascaded source comes from hi select field
// R5: dead low-frequency clock gives no ticks
// R6: clock gate off stops both timers
// R7: gate resets off; set before control writes
// R8: never drop gate while timer runs; gate writes are taken whatever the run bits hold
// R9: independent 8-bit, cascaded 16-bit operation
// R10: software writes 8-bit compare value
// R11: double buffer delays compare update
// R12: mode writes ignored while running
// R13: run bit starts up counter on ticks
// R14: match raises irq, clears, resumes
// R15: run cleared stops and zeroes counter
// R16: hi timer mirrors lo timer
// R17: cascade bit joins timers into 16 bits
// R18: external select zero means internal clock
// R19: stop mode clears both run bits
module dit_top
	import dit_pkg::*;
#(
	parameter int AW = 8                     // apb address width
) (
	// apb slave
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// chip power state and low-frequency clock pins
	input  wire logic          low_freq_clk, // raw oscillator
	input  wire logic          lf_osc_ok,    // oscillator running
	input  wire logic          slow_mode,    // slow or sleep mode
	input  wire logic          stop_mode,    // chip stop mode
	// interrupt and match pulses
	output logic               irq,          // level interrupt
	output logic               match_irq_lo, // one-cycle pulse
	output logic               match_irq_hi  // one-cycle pulse
);

	// ========================================================
	// pin synchronisers (first stage read only by second)
	// ========================================================
	logic [3:0] sy1_q, sy2_q;  // {lfclk, lfok, slow, stop}
	logic       lf_prev_q;     // edge detector on synced clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q     <= 4'h0;
			sy2_q     <= 4'h0;
			lf_prev_q <= 1'b0;
		end else begin
			sy1_q     <= {low_freq_clk, lf_osc_ok, slow_mode, stop_mode};
			sy2_q     <= sy1_q;
			lf_prev_q <= sy2_q[3];
		end
	end
	logic lf_edge, stop_s;
	dit_env_t env;
	assign lf_edge = sy2_q[3] & ~lf_prev_q;
	assign stop_s  = sy2_q[0];

	// ========================================================
	// software registers
	// ========================================================
	logic      gate_q, gate_d;       // pair_clk_gate_en
	logic      run_lo_q, run_lo_d;   // run_bit_lo
	logic      run_hi_q, run_hi_d;   // run_bit_hi
	logic      casc_q, casc_d;       // cascade control
	logic      lfsel_q, lfsel_d;     // low-frequency taps
	dit_mode_t mode_lo_q, mode_lo_d; // timer_mode_reg lo
	dit_mode_t mode_hi_q, mode_hi_d; // timer_mode_reg hi
	logic [1:0] sts_q, sts_d;        // sticky match status
	logic [1:0] ien_q, ien_d;        // interrupt enables
	logic [31:0] rd_d;               // read data next
	logic [31:0] prdata_q;           // registered read data
	assign env = '{slow: sy2_q[1], lfsel: lfsel_q, lfok: sy2_q[2]};

	// bus decode: zero-wait slave, write lands at access edge
	logic wr, rd_setup, hit_map;
	logic [7:0] a;
	assign a        = 8'(paddr);
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit_map  = (a[1:0] == 2'h0) && (a <= OFS_CFG);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit_map;
	assign prdata   = prdata_q;

	// ========================================================
	// prescalers: gear clock is pclk, lf counts synced edges
	// ========================================================
	logic [GPRE_W-1:0] gpre_q, gpre_d;
	logic [LPRE_W-1:0] lpre_q, lpre_d;
	logic [7:0]        gear_t;         // tick per gear code
	logic [2:0]        lf_t;           // {lf/4, lf/8, lf/16}
	always_comb begin
		// gating off clears the dividers to zero as well
		gpre_d = gate_q ? gpre_q + GPRE_W'(1) : '0; // R6
		lpre_d = lpre_q;
		if (!gate_q) begin
			lpre_d = '0;
		end else if (lf_edge) begin
			lpre_d = lpre_q + LPRE_W'(1);
		end
		for (int c = 0; c < 8; c++) begin
			gear_t[c] = gate_q &&
				((gpre_q & gear_mask(3'(c))) == gear_mask(3'(c)));
		end
		lf_t = {lf_edge & (&lpre_q[1:0]), lf_edge & (&lpre_q[2:0]),
			lf_edge & (&lpre_q[3:0])} & {3{gate_q}};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpre_q <= '0;
			lpre_q <= '0;
		end else begin
			gpre_q <= gpre_d;
			lpre_q <= lpre_d;
		end
	end

	// source tick for a select code in the current power mode
	function automatic logic src_tick(input logic [2:0] sel,
		input dit_env_t e, input logic [7:0] g, input logic [2:0] l);
		logic lf_use;
		logic t;
		lf_use = e.slow || (e.lfsel &&
			(sel == SRC_DIV16 || sel == SRC_DIV8));
		if (e.slow) begin
			// only three codes reach a tap in slow modes; R3
			unique case (sel)
				SRC_DIV16: t = l[0];
				SRC_DIV8:  t = l[1];
				SRC_DIV1:  t = l[2];
				default:   t = 1'b0;
			endcase
		end else if (lf_use) begin
			t = (sel == SRC_DIV16) ? l[0] : l[1]; // R2
		end else begin
			t = g[sel]; // R2
		end
		// an idle oscillator feeds nothing, timer stays put
		src_tick = t && !(lf_use && !e.lfok); // R5
	endfunction : src_tick

	// ========================================================
	// counters
	// ========================================================
	logic tick_lo, tick_hi, ivl_lo, ivl_hi, t16;
	logic inc_lo, inc_hi, clr_lo, clr_hi, hit_lo, hit_hi, hit16;
	logic wr_cmp_lo, wr_cmp_hi;
	logic [7:0] cnt_lo, cnt_hi, act_lo, act_hi, buf_lo, buf_hi;
	always_comb begin
		// cascaded pair takes its clock from the hi field; R4
		tick_lo = src_tick(casc_q ? mode_hi_q.src_clk_sel :
			mode_lo_q.src_clk_sel, env, gear_t, lf_t);
		tick_hi = src_tick(mode_hi_q.src_clk_sel, env, gear_t, lf_t);
		// interval mode: op 00/01, internal clock, no cascade
		ivl_lo = !mode_lo_q.op_mode_sel[1] && !mode_lo_q.ext_clk_sel
			&& !casc_q; // R1 R18
		ivl_hi = !mode_hi_q.op_mode_sel[1] && !mode_hi_q.ext_clk_sel
			&& !casc_q; // R16
		// 16-bit timer: hi run bit and hi mode govern the pair, lo mode only its dbuf
		t16 = casc_q && run_hi_q && !mode_hi_q.op_mode_sel[1]
			&& !mode_hi_q.ext_clk_sel; // R9 R17
		// match one tick ahead so the period equals compare
		hit_lo = ivl_lo && run_lo_q && tick_lo
			&& (cnt_lo + 8'h01 == act_lo); // R13 R14
		hit_hi = ivl_hi && run_hi_q && tick_hi
			&& (cnt_hi + 8'h01 == act_hi); // R16
		hit16  = t16 && tick_lo
			&& ({cnt_hi, cnt_lo} + 16'h0001 == {act_hi, act_lo});
		inc_lo = (ivl_lo && run_lo_q && tick_lo) || (t16 && tick_lo);
		inc_hi = (ivl_hi && run_hi_q && tick_hi)
			|| (t16 && tick_lo && cnt_lo == 8'hff);
		clr_lo = hit_lo || hit16;
		clr_hi = hit_hi || hit16;
		wr_cmp_lo = wr && gate_q && a == OFS_CMP_LO; // R10
		wr_cmp_hi = wr && gate_q && a == OFS_CMP_HI;
	end

	// lo timer; halted when its run bit governs and is clear
	dit_chan #(.W(8)) u_lo (
		.pclk      (pclk),
		.presetn   (presetn),
		.inc       (inc_lo),
		.clr       (clr_lo),
		.halt      (casc_q ? !run_hi_q : !run_lo_q), // R15
		.cmp_wr    (wr_cmp_lo),
		.cmp_wdata (pwdata[7:0]),
		.dbuf_en   (mode_lo_q.dbuf_enable), // R11
		.cnt_q     (cnt_lo),
		.act_q     (act_lo),
		.buf_q     (buf_lo)
	);

	// hi timer, same logic with its own fields, but lo dbuf when cascaded; R16
	dit_chan #(.W(8)) u_hi (
		.pclk      (pclk),
		.presetn   (presetn),
		.inc       (inc_hi),
		.clr       (clr_hi),
		.halt      (!run_hi_q),
		.cmp_wr    (wr_cmp_hi),
		.cmp_wdata (pwdata[7:0]),
		.dbuf_en   (casc_q ? mode_lo_q.dbuf_enable :
			mode_hi_q.dbuf_enable),
		.cnt_q     (cnt_hi),
		.act_q     (act_hi),
		.buf_q     (buf_hi)
	);

	// ========================================================
	// register writes, status and read mux
	// ========================================================
	logic busy_lo, busy_hi;
	assign busy_lo = run_lo_q || (casc_q && run_hi_q);
	assign busy_hi = run_hi_q;
	always_comb begin
		gate_d    = gate_q;
		run_lo_d  = run_lo_q;
		run_hi_d  = run_hi_q;
		casc_d    = casc_q;
		lfsel_d   = lfsel_q;
		mode_lo_d = mode_lo_q;
		mode_hi_d = mode_hi_q;
		ien_d     = ien_q;
		sts_d     = sts_q;
		if (wr && a == OFS_GATE) begin
			gate_d = pwdata[GATE_EN_BIT]; // R6 R8
		end
		// timer controls need the clock gate open first; R7
		if (wr && gate_q) begin
			unique case (a)
				OFS_PAIR: begin
					run_lo_d = pwdata[RUN_LO_BIT]; // R13 R15
					run_hi_d = pwdata[RUN_HI_BIT];
					// cascade only moves while both are stopped
					if (!run_lo_q && !run_hi_q) begin
						casc_d = pwdata[CASC_BIT]; // R17
					end
				end
				OFS_MODE_LO: if (!busy_lo) begin
					mode_lo_d = dit_mode_t'(pwdata[7:0]); // R12
				end
				OFS_MODE_HI: if (!busy_hi) begin
					mode_hi_d = dit_mode_t'(pwdata[7:0]); // R12
				end
				OFS_IEN: ien_d = pwdata[1:0];
				OFS_CFG: lfsel_d = pwdata[LFSEL_BIT];
				OFS_CLR: sts_d = sts_q & ~pwdata[1:0];
				default: ;
			endcase
		end
		// stop mode forces both timers off; R19
		if (stop_s) begin
			run_lo_d = 1'b0;
			run_hi_d = 1'b0;
		end
		// a match in the clearing cycle still lands
		sts_d[STS_LO_BIT] = sts_d[STS_LO_BIT] | hit_lo | hit16;
		sts_d[STS_HI_BIT] = sts_d[STS_HI_BIT] | hit_hi;
		// read data prepared in setup, shown in access
		rd_d = prdata_q;
		if (rd_setup) begin
			rd_d = 32'h0000_0000;
			unique case (a)
				OFS_GATE:    rd_d[GATE_EN_BIT] = gate_q;
				OFS_PAIR:    rd_d[2:0] = {casc_q, run_hi_q, run_lo_q};
				OFS_MODE_LO: rd_d[7:0] = mode_lo_q;
				OFS_MODE_HI: rd_d[7:0] = mode_hi_q;
				OFS_CMP_LO:  rd_d[7:0] = buf_lo;
				OFS_CMP_HI:  rd_d[7:0] = buf_hi;
				OFS_CNT_LO:  rd_d[7:0] = cnt_lo;
				OFS_CNT_HI:  rd_d[7:0] = cnt_hi;
				OFS_STS:     rd_d[1:0] = sts_q;
				OFS_IEN:     rd_d[1:0] = ien_q;
				OFS_CFG:     rd_d[LFSEL_BIT] = lfsel_q;
				default:     rd_d = 32'h0000_0000;
			endcase
		end
	end

	// register stage for all software state but the compare values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q       <= 1'b0; // R7
			run_lo_q     <= 1'b0;
			run_hi_q     <= 1'b0;
			casc_q       <= 1'b0;
			lfsel_q      <= 1'b0;
			mode_lo_q    <= dit_mode_t'(MODE_RST);
			mode_hi_q    <= dit_mode_t'(MODE_RST);
			sts_q        <= 2'h0;
			ien_q        <= IEN_RST;
			prdata_q     <= 32'h0000_0000;
			match_irq_lo <= 1'b0;
			match_irq_hi <= 1'b0;
		end else begin
			gate_q       <= gate_d;
			run_lo_q     <= run_lo_d;
			run_hi_q     <= run_hi_d;
			casc_q       <= casc_d;
			lfsel_q      <= lfsel_d;
			mode_lo_q    <= mode_lo_d;
			mode_hi_q    <= mode_hi_d;
			sts_q        <= sts_d;
			ien_q        <= ien_d;
			prdata_q     <= rd_d;
			match_irq_lo <= hit_lo | hit16; // R14
			match_irq_hi <= hit_hi;
		end
	end
	assign irq = |(sts_q & ien_q);

	// ========================================================
	// assertions
	// ========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_IVL_ONLY: assert property ( // R1
		!ivl_lo && !casc_q |=> cnt_lo == 8'h00 || $stable(cnt_lo))
		else $error("lo counted outside interval mode");
	AST_FAST_CODE: assert property ( // R2
		gate_q && !env.slow && mode_lo_q.src_clk_sel == 3'h7
		&& !casc_q |-> tick_lo)
		else $error("code 111 did not tick every cycle");
	AST_CASC_SRC: assert property ( // R4
		casc_q && gate_q && !env.slow
		&& mode_hi_q.src_clk_sel == SRC_DIV1 |-> tick_lo)
		else $error("cascade not on hi clock select");
	AST_LF_DEAD: assert property ( // R5
		env.slow && !env.lfok |-> !tick_lo && !tick_hi)
		else $error("tick from stopped oscillator");
	AST_GATE_OFF: assert property ( // R6
		!gate_q && !stop_s && !casc_q |=> $stable(cnt_lo))
		else $error("counter moved with gate off");
	AST_CTL_LOCK: assert property ( // R7
		wr && a == OFS_PAIR && !gate_q && !stop_s
		|=> $stable({run_hi_q, run_lo_q, casc_q}))
		else $error("control written with gate off");
	AST_MODE_LOCK: assert property ( // R12
		wr && a == OFS_MODE_LO && busy_lo |=> $stable(mode_lo_q))
		else $error("mode changed while running");
	AST_MATCH: assert property ( // R14
		hit_lo |=> cnt_lo == 8'h00 && sts_q[STS_LO_BIT]
		&& match_irq_lo ##1 !match_irq_lo || $past(hit_lo))
		else $error("match did not clear and flag");
	AST_STOPPED: assert property ( // R15
		!run_lo_q && !casc_q |=> cnt_lo == 8'h00)
		else $error("stopped counter not zero");
	AST_STOP_MODE: assert property ( // R19
		stop_s |=> !run_lo_q && !run_hi_q)
		else $error("stop mode left a timer running");
	AST_IRQ: assert property ( // R16
		hit_hi |=> sts_q[STS_HI_BIT] && (irq || !ien_q[STS_HI_BIT]))
		else $error("hi match did not raise status or interrupt");

	COV_LO_MATCH: cover property (run_lo_q ##1 hit_lo ##[1:300] hit_lo);
	COV_HI_MATCH: cover property (hit_hi && ien_q[STS_HI_BIT]);
	COV_CASC:     cover property (hit16);
	COV_SLOW:     cover property (env.slow && tick_lo);

endmodule : dit_top
